/* File: pio_pkg.sv */
// pio_pkg: constants and types of the parallel I/O ports
// Behaviour
// - first port bit: 0 GPIO, 1 peripheral
// - GPIO direction bit: 0 input, 1 output
// - reset clears first port select and direction
// - data write always loads latch; outputs drive it
// - read: outputs give latch, inputs give pin
// - peripheral pin: direction from peripheral, not register
// - peripheral pin reads peripheral input or driver
// - GPIO pin feeds peripheral fixed substitute level
// - GPIO transmit clock pin: take receive clock
// - GPIO DMA request pin: request held low
// - second pins 7-0 like first; pin7 watchdog
// - GPIO second pins: timer inputs held low
// - input pin 8 feeds refresh request when selected
// - pins 11-8 follow direction; reset clears
// - reset clears global interrupt mode register
// - pins 11-8 same latch and read-back
// - input pins 11-8: falling edge requests interrupt
// - four requests fixed priority, each maskable
// - reserved bits read as zero
package pio_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFF_PA_FSEL = 8'h00;
  localparam logic [7:0]  OFF_PA_DIR  = 8'h04;
  localparam logic [7:0]  OFF_PA_DATA = 8'h08;
  localparam logic [7:0]  OFF_PB_FSEL = 8'h0C;
  localparam logic [7:0]  OFF_PB_DIR  = 8'h10;
  localparam logic [7:0]  OFF_PB_DATA = 8'h14;
  localparam logic [7:0]  OFF_IMASK   = 8'h18;
  localparam logic [7:0]  OFF_GLOBAL_INTERRUPT_MODE_REGISTER    = 8'h1C;
  localparam logic [7:0]  OFF_SCR     = 8'h20;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] PA_FSEL_RST = 16'h0000;
  localparam logic [15:0] PA_DIR_RST  = 16'h0000;
  localparam logic [15:0] PA_LAT_RST  = 16'h0000;
  localparam logic [7:0]  PB_FSEL_RST = 8'h80;
  localparam logic [11:0] PB_DIR_RST  = 12'h000;
  localparam logic [11:0] PB_LAT_RST  = 12'h000;
  localparam logic [3:0]  IMASK_RST   = 4'h0;
  localparam logic        GLOBAL_INTERRUPT_MODE_REGISTER_RST    = 1'b0;
  localparam logic        SCR_RST     = 1'b0;
  // ----------------------------------------------------------------
  // fields and substitute levels
  // ----------------------------------------------------------------
  localparam logic [15:0] PA_SUB      = 16'h8000;
  localparam logic [7:0]  PB_SUB      = 8'h00;
  localparam int          PA_CHANNEL2_RECEIVE_CLOCK    = 2;
  localparam int          PA_CHANNEL2_TRANSMIT_CLOCK    = 3;
  localparam int          PA_RCLK3    = 10;
  localparam int          PA_TCLK3    = 11;
  localparam int          PA_DMA_REQUEST_INPUT     = 13;
  localparam int          PB_WATCHDOG_OUTPUT     = 7;
  localparam int          PB_RFSH     = 8;
  localparam int          GLOBAL_INTERRUPT_MODE_REGISTER_EN_BIT = 0;
  localparam int          SCR_RFSH_BIT = 0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // bus carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } pio_axil_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pio_axil_rsp_t;
endpackage

/* File: pio_ports.sv */
// pio_ports: two parallel I/O ports with AXI4-Lite register access
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module pio_ports (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire pio_pkg::pio_axil_req_t axi_req,
  output pio_pkg::pio_axil_rsp_t      axi_rsp,
  input  wire logic [15:0]            pa_in,
  output logic [15:0]                 pa_out,
  output logic [15:0]                 pa_oe,
  input  wire logic [11:0]            pb_in,
  output logic [11:0]                 pb_out,
  output logic [11:0]                 pb_oe,
  input  wire logic [15:0]            pa_per_out,
  input  wire logic [15:0]            pa_per_oe,
  output logic [15:0]                 pa_per_in,
  input  wire logic [6:0]             pb_per_out,
  input  wire logic [6:0]             pb_per_oe,
  input  wire logic                   watchdog_output_n,
  output logic [7:0]                  pb_per_in,
  output logic                        refresh_req,
  output logic [3:0]                  pb_irq
);
  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // dedicated pins show the peripheral's driver or its input level
  function automatic logic [15:0] readback(input logic [15:0] fsel,
                                           input logic [15:0] dir,
                                           input logic [15:0] lat,
                                           input logic [15:0] pin,
                                           input logic [15:0] po,
                                           input logic [15:0] pe);
    logic [15:0] gp;
    logic [15:0] ded;
    gp       = (dir & lat) | (~dir & pin);
    ded      = (pe & po) | (~pe & pin);
    readback = (fsel & ded) | (~fsel & gp);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0]             pa_fsel_reg;
  logic [15:0]             pa_dir_reg;
  logic [15:0]             pa_lat_reg;
  logic [7:0]              pb_fsel_reg;
  logic [11:0]             pb_dir_reg;
  logic [11:0]             pb_lat_reg;
  logic [3:0]              imask_reg;
  logic                    global_interrupt_mode_register_reg;
  logic                    scr_reg;
  logic                    aw_have_reg;
  logic [pio_pkg::ADDR_W-1:0] aw_addr_reg;
  logic                    w_have_reg;
  logic [31:0]             w_data_reg;
  logic [3:0]              w_strb_reg;
  logic                    bvalid_reg;
  logic [1:0]              bresp_reg;
  logic                    rvalid_reg;
  logic [31:0]             rdata_reg;
  logic [1:0]              rresp_reg;
  logic [3:0]              sync1_reg;
  logic [3:0]              sync2_reg;
  logic [3:0]              sync3_reg;
  logic                    do_wr;
  logic                    wr_ok;
  logic [31:0]             rd_word;
  logic                    rd_ok;
  logic [15:0]             pb_fsel16;
  logic [15:0]             pb_po16;
  logic [15:0]             pb_pe16;
  logic [15:0]             pa_sub_next;
  logic [3:0]              fall;

  assign pb_fsel16 = {8'h00, pb_fsel_reg};
  // watchdog pin is open drain: only ever pulls low
  assign pb_po16   = {9'h000, pb_per_out};
  assign pb_pe16   = {8'h00, ~watchdog_output_n, pb_per_oe};

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign do_wr = aw_have_reg & w_have_reg;

  always_comb begin
    unique case (aw_addr_reg)
      pio_pkg::OFF_PA_FSEL, pio_pkg::OFF_PA_DIR, pio_pkg::OFF_PA_DATA,
      pio_pkg::OFF_PB_FSEL, pio_pkg::OFF_PB_DIR, pio_pkg::OFF_PB_DATA,
      pio_pkg::OFF_IMASK, pio_pkg::OFF_GLOBAL_INTERRUPT_MODE_REGISTER, pio_pkg::OFF_SCR: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_have_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= pio_pkg::RESP_OKAY;
    end else begin
      if (axi_req.awvalid && axi_rsp.awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= axi_req.awaddr;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= axi_req.wdata;
        w_strb_reg <= axi_req.wstrb;
      end
      if (do_wr) begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_ok ? pio_pkg::RESP_OKAY : pio_pkg::RESP_SLVERR;
      end else if (bvalid_reg && axi_req.bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pa_fsel_reg <= pio_pkg::PA_FSEL_RST;
      pa_dir_reg  <= pio_pkg::PA_DIR_RST;
      pa_lat_reg  <= pio_pkg::PA_LAT_RST;
      pb_fsel_reg <= pio_pkg::PB_FSEL_RST;
      pb_dir_reg  <= pio_pkg::PB_DIR_RST;
      pb_lat_reg  <= pio_pkg::PB_LAT_RST;
      imask_reg   <= pio_pkg::IMASK_RST;
      global_interrupt_mode_register_reg    <= pio_pkg::GLOBAL_INTERRUPT_MODE_REGISTER_RST;
      scr_reg     <= pio_pkg::SCR_RST;
    end else if (do_wr) begin
      unique case (aw_addr_reg)
        pio_pkg::OFF_PA_FSEL: pa_fsel_reg <= merge16(pa_fsel_reg, w_data_reg, w_strb_reg);
        pio_pkg::OFF_PA_DIR:  pa_dir_reg  <= merge16(pa_dir_reg, w_data_reg, w_strb_reg);
        // the latch loads whatever the pin mode
        pio_pkg::OFF_PA_DATA: pa_lat_reg  <= merge16(pa_lat_reg, w_data_reg, w_strb_reg);
        pio_pkg::OFF_PB_FSEL: pb_fsel_reg <= w_strb_reg[0] ? w_data_reg[7:0] : pb_fsel_reg;
        pio_pkg::OFF_PB_DIR:
          pb_dir_reg <= 12'(merge16({4'h0, pb_dir_reg}, w_data_reg, w_strb_reg));
        pio_pkg::OFF_PB_DATA:
          pb_lat_reg <= 12'(merge16({4'h0, pb_lat_reg}, w_data_reg, w_strb_reg));
        pio_pkg::OFF_IMASK: imask_reg <= w_strb_reg[0] ? w_data_reg[3:0] : imask_reg;
        pio_pkg::OFF_GLOBAL_INTERRUPT_MODE_REGISTER:
          global_interrupt_mode_register_reg <= w_strb_reg[0] ? w_data_reg[pio_pkg::GLOBAL_INTERRUPT_MODE_REGISTER_EN_BIT] : global_interrupt_mode_register_reg;
        pio_pkg::OFF_SCR:
          scr_reg <= w_strb_reg[0] ? w_data_reg[pio_pkg::SCR_RFSH_BIT] : scr_reg;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    unique case (axi_req.araddr)
      pio_pkg::OFF_PA_FSEL: rd_word[15:0] = pa_fsel_reg;
      pio_pkg::OFF_PA_DIR:  rd_word[15:0] = pa_dir_reg;
      pio_pkg::OFF_PA_DATA:
        rd_word[15:0] = readback(pa_fsel_reg, pa_dir_reg, pa_lat_reg,
                                 pa_in, pa_per_out, pa_per_oe);
      pio_pkg::OFF_PB_FSEL: rd_word[7:0]  = pb_fsel_reg;
      pio_pkg::OFF_PB_DIR:  rd_word[11:0] = pb_dir_reg;
      pio_pkg::OFF_PB_DATA:
        rd_word[11:0] = 12'(readback(pb_fsel16, {4'h0, pb_dir_reg}, {4'h0, pb_lat_reg},
                                     {4'h0, pb_in}, pb_po16, pb_pe16));
      pio_pkg::OFF_IMASK: rd_word[3:0] = imask_reg;
      pio_pkg::OFF_GLOBAL_INTERRUPT_MODE_REGISTER:  rd_word[pio_pkg::GLOBAL_INTERRUPT_MODE_REGISTER_EN_BIT] = global_interrupt_mode_register_reg;
      pio_pkg::OFF_SCR:   rd_word[pio_pkg::SCR_RFSH_BIT] = scr_reg;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= pio_pkg::RESP_OKAY;
    end else if (axi_req.arvalid && axi_rsp.arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_ok ? pio_pkg::RESP_OKAY : pio_pkg::RESP_SLVERR;
    end else if (rvalid_reg && axi_req.rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  always_comb begin
    axi_rsp.awready = ~aw_have_reg & ~bvalid_reg;
    axi_rsp.wready  = ~w_have_reg & ~bvalid_reg;
    axi_rsp.bvalid  = bvalid_reg;
    axi_rsp.bresp   = bresp_reg;
    axi_rsp.arready = ~rvalid_reg;
    axi_rsp.rvalid  = rvalid_reg;
    axi_rsp.rdata   = rdata_reg;
    axi_rsp.rresp   = rresp_reg;
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pa_out <= 16'h0000;
      pa_oe  <= 16'h0000;
      pb_out <= 12'h000;
      pb_oe  <= 12'h000;
    end else begin
      pa_out <= (pa_fsel_reg & pa_per_out) | (~pa_fsel_reg & pa_lat_reg);
      pa_oe  <= (pa_fsel_reg & pa_per_oe) | (~pa_fsel_reg & pa_dir_reg);
      pb_out <= 12'((pb_fsel16 & pb_po16) | (~pb_fsel16 & {4'h0, pb_lat_reg}));
      pb_oe  <= 12'((pb_fsel16 & pb_pe16) | (~pb_fsel16 & {4'h0, pb_dir_reg}));
    end
  end

  // ----------------------------------------------------------------
  // peripheral inputs with substitution
  // ----------------------------------------------------------------
  always_comb begin
    pa_sub_next = (pa_fsel_reg & pa_in) | (~pa_fsel_reg & pio_pkg::PA_SUB);
    // one external clock then serves receiver and transmitter
    if (!pa_fsel_reg[pio_pkg::PA_CHANNEL2_TRANSMIT_CLOCK]) begin
      pa_sub_next[pio_pkg::PA_CHANNEL2_TRANSMIT_CLOCK] = pa_sub_next[pio_pkg::PA_CHANNEL2_RECEIVE_CLOCK];
    end
    if (!pa_fsel_reg[pio_pkg::PA_TCLK3]) begin
      pa_sub_next[pio_pkg::PA_TCLK3] = pa_sub_next[pio_pkg::PA_RCLK3];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pa_per_in   <= 16'h0000;
      pb_per_in   <= 8'h00;
      refresh_req <= 1'b0;
    end else begin
      pa_per_in   <= pa_sub_next;
      pb_per_in   <= (pb_fsel_reg & pb_in[7:0]) | (~pb_fsel_reg & pio_pkg::PB_SUB);
      refresh_req <= scr_reg & ~pb_dir_reg[pio_pkg::PB_RFSH] & pb_in[pio_pkg::PB_RFSH];
    end
  end

  // ----------------------------------------------------------------
  // falling-edge requests on pins 11-8
  // ----------------------------------------------------------------
  // edges are taken after the second flop so a slow edge yields one pulse
  assign fall = sync3_reg & ~sync2_reg & ~pb_dir_reg[11:8];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
      pb_irq    <= 4'h0;
    end else begin
      sync1_reg <= pb_in[11:8];
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      // bit 0 is pin 8 (lowest priority) up to bit 3, pin 11
      pb_irq    <= fall & imask_reg & {4{global_interrupt_mode_register_reg}};
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence pa_data_wr;
    do_wr && aw_addr_reg == pio_pkg::OFF_PA_DATA && w_strb_reg == 4'hF;
  endsequence

  sequence pb8_fall;
    pb_in[8] [*3] ##1 (!pb_in[8] && !pb_dir_reg[8] && imask_reg[0] && global_interrupt_mode_register_reg) [*3];
  endsequence

  latch_load_a: assert property (pa_data_wr |=> pa_lat_reg == $past(w_data_reg[15:0]))
    else $error("data write did not load latch");

  gp_drive_a: assert property (pa_data_wr ##1 1'b1
      |=> ((pa_out ^ $past(pa_lat_reg)) & ~$past(pa_fsel_reg)) == 16'h0000
      && ((pa_oe ^ $past(pa_dir_reg)) & ~$past(pa_fsel_reg)) == 16'h0000)
    else $error("gp output not driven from latch");

  gp_input_a: assert property (pa_fsel_reg == 16'h0000 && pa_dir_reg == 16'h0000
      |=> pa_oe == 16'h0000)
    else $error("gp input pin driven");

  read_back_a: assert property (axi_req.arvalid && axi_rsp.arready
      && axi_req.araddr == pio_pkg::OFF_PA_DATA && pa_fsel_reg == 16'h0000
      |=> rdata_reg[15:0] == (($past(pa_dir_reg) & $past(pa_lat_reg))
          | (~$past(pa_dir_reg) & $past(pa_in))) && rdata_reg[31:16] == 16'h0000)
    else $error("port data read-back wrong");

  reserved_zero_a: assert property (rvalid_reg && $past(axi_req.araddr) ==
      pio_pkg::OFF_PB_DATA && $rose(rvalid_reg) |-> rdata_reg[31:12] == 20'h00000)
    else $error("reserved bits read nonzero");

  subst_tclk_a: assert property (!pa_fsel_reg[3] && !pa_fsel_reg[2]
      |=> pa_per_in[3] == 1'b0 && pa_per_in[2] == 1'b0)
    else $error("transmit clock substitute wrong");

  dma_request_input_low_a: assert property (!pa_fsel_reg[pio_pkg::PA_DMA_REQUEST_INPUT] && !pa_fsel_reg[15]
      |=> !pa_per_in[pio_pkg::PA_DMA_REQUEST_INPUT] && pa_per_in[15])
    else $error("dma request or done substitute wrong");

  timer_low_a: assert property (!pb_fsel_reg[3] && !pb_fsel_reg[5]
      |=> !pb_per_in[3] && !pb_per_in[5])
    else $error("timer input not held low");

  watchdog_output_pull_a: assert property (pb_fsel_reg[7] && !watchdog_output_n
      |=> pb_oe[7] && !pb_out[7])
    else $error("watchdog pin not pulled low");

  edge_irq_a: assert property (pb8_fall |=> pb_irq[0] ##1 !pb_irq[0])
    else $error("falling edge did not give one pulse");

  mask_gate_a: assert property (!imask_reg[0] |=> !pb_irq[0])
    else $error("masked request reached output");

  // ----------------------------------------------------------------
  // per-bit mux checks, all but the last two true on every cycle for every pin; only the substitute check skips the transmit clock pins 3 and 11
  // ----------------------------------------------------------------
  per_drive_a: assert property (1'b1
      |=> ((pa_out ^ $past(pa_per_out)) & $past(pa_fsel_reg)) == 16'h0000)
    else $error("dedicated pin not driven by peripheral");

  per_dir_a: assert property (1'b1
      |=> ((pa_oe ^ $past(pa_per_oe)) & $past(pa_fsel_reg)) == 16'h0000)
    else $error("dedicated pin direction not from peripheral");

  subst_level_a: assert property (1'b1
      |=> ((pa_per_in ^ pio_pkg::PA_SUB) & ~$past(pa_fsel_reg) & ~16'h0808) == 16'h0000)
    else $error("peripheral substitute level wrong");

  pb_pass_a: assert property (1'b1
      |=> ((pb_per_in ^ $past(pb_in[7:0])) & $past(pb_fsel_reg)) == 8'h00)
    else $error("second port peripheral input wrong");

  pb_dir_a: assert property (1'b1 |=> pb_oe[11:8] == $past(pb_dir_reg[11:8]))
    else $error("upper pin direction wrong");

  pb_latch_a: assert property (1'b1 |=> pb_out[11:8] == $past(pb_lat_reg[11:8]))
    else $error("upper pin latch not driven");

  rfsh_off_a: assert property (!scr_reg |=> !refresh_req)
    else $error("refresh request without select");

  out_no_irq_a: assert property (pb_dir_reg[8] |=> !pb_irq[0])
    else $error("output pin raised a request");

endmodule // pio_ports

/* File: pio_board.sv */
// pio_board: board-side model of the port pins
`timescale 1ns/1ps
module pio_board (
  input  wire logic [15:0] pa_out,
  input  wire logic [15:0] pa_oe,
  input  wire logic [11:0] pb_out,
  input  wire logic [11:0] pb_oe,
  input  wire logic [15:0] ext_a,
  input  wire logic [11:0] ext_b,
  output logic      [15:0] pa_pin,
  output logic      [11:0] pb_pin
);
  // no pullups on the board: the board drives every line the port leaves free,
  // so a wrong enable shows up as a wrong level
  assign pa_pin = (pa_oe & pa_out) | (~pa_oe & ext_a);
  assign pb_pin = (pb_oe & pb_out) | (~pb_oe & ext_b);
endmodule // pio_board

/* File: pio_ports_bench.sv */
// pio_ports_bench: self-checking bench of the parallel I/O ports
`timescale 1ns/1ps
module pio_ports_bench;
  logic                   clk;
  logic                   resetn;
  pio_pkg::pio_axil_req_t req;
  pio_pkg::pio_axil_rsp_t rsp;
  logic [15:0]            pa_out, pa_oe, pa_pin, pa_per_in, ext_a, pao, pae, sa_f, sa_d, sa_l;
  logic [11:0]            pb_out, pb_oe, pb_pin, ext_b, sb_d, sb_l;
  logic [6:0]             pbo, pbe;
  logic [7:0]             pb_per_in, sb_f;
  logic [3:0]             pb_irq, s_im, cnt, o;
  logic                   watchdog_output_n, refresh_req, s_gi, s_sc;
  integer                 seed = 32'h2002;
  int                     n_mismatch, tests_run, n, m;
  localparam logic [7:0]  OFFS [9] = '{pio_pkg::OFF_PA_FSEL, pio_pkg::OFF_PA_DIR,
    pio_pkg::OFF_PA_DATA, pio_pkg::OFF_PB_FSEL, pio_pkg::OFF_PB_DIR, pio_pkg::OFF_PB_DATA,
    pio_pkg::OFF_IMASK, pio_pkg::OFF_GLOBAL_INTERRUPT_MODE_REGISTER, pio_pkg::OFF_SCR};

  pio_ports u_dut (.clk(clk), .resetn(resetn), .axi_req(req), .axi_rsp(rsp), .pa_in(pa_pin),
    .pa_out(pa_out), .pa_oe(pa_oe), .pb_in(pb_pin), .pb_out(pb_out), .pb_oe(pb_oe),
    .pa_per_out(pao), .pa_per_oe(pae), .pa_per_in(pa_per_in), .pb_per_out(pbo),
    .pb_per_oe(pbe), .watchdog_output_n(watchdog_output_n), .pb_per_in(pb_per_in), .refresh_req(refresh_req),
    .pb_irq(pb_irq));
  pio_board u_board (.pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe),
    .ext_a(ext_a), .ext_b(ext_b), .pa_pin(pa_pin), .pb_pin(pb_pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic test_done;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic stuck(input int k);
    if (k >= 60) begin
      n_mismatch++;
      $display("Error handshake expected answer seen none");
      test_done();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
    int   k;
    logic aw, w;
    aw = 1'b1;
    w  = 1'b1;
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    for (k = 0; k < 60; k++) begin
      @(posedge clk);
      if (!aw && !w && rsp.bvalid) break;
      if (aw && rsp.awready) begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
    end
    stuck(k);
    chk("bresp", 32'(err ? pio_pkg::RESP_SLVERR : pio_pkg::RESP_OKAY), 32'(rsp.bresp));
    req.bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
    int   k;
    logic ar;
    ar = 1'b1;
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    for (k = 0; k < 60; k++) begin
      @(posedge clk);
      if (!ar && rsp.rvalid) break;
      if (ar && rsp.arready) begin
        ar = 1'b0;
        req.arvalid <= 1'b0;
      end
    end
    stuck(k);
    chk("rdata", e, rsp.rdata);
    chk("rresp", 32'(err ? pio_pkg::RESP_SLVERR : pio_pkg::RESP_OKAY), 32'(rsp.rresp));
    req.rready <= 1'b0;
    @(posedge clk);
  endtask
  // returns {enable, pin level} of a port from its settings and the board
  function automatic logic [31:0] pins(input logic [15:0] f, d, l, po, pe, x);
    logic [15:0] oe, out;
    oe  = (f & pe) | (~f & d);
    out = (f & po) | (~f & l);
    return {oe, (oe & out) | (~oe & x)};
  endfunction
  task automatic look;
    logic [31:0] a, b;
    logic [31:0] e [9];
    logic [15:0] pi;
    a = pins(sa_f, sa_d, sa_l, pao, pae, ext_a);
    b = pins({8'h00, sb_f}, {4'h0, sb_d}, {4'h0, sb_l}, {9'h000, pbo}, {8'h00, ~watchdog_output_n, pbe},
      {4'h0, ext_b});
    pi = (sa_f & a[15:0]) | (~sa_f & 16'h8000);
    pi[3] = sa_f[3] ? a[3] : pi[2];
    pi[11] = sa_f[11] ? a[11] : pi[10];
    e = '{32'(sa_f), 32'(sa_d), 32'(a[15:0]), 32'(sb_f), 32'(sb_d), 32'(b[11:0]), 32'(s_im),
      32'(s_gi), 32'(s_sc)};
    repeat (3) @(posedge clk);
    chk("pa_oe", 32'(a[31:16]), 32'(pa_oe));
    chk("pa_out", 32'(a[31:16] & a[15:0]), 32'(pa_oe & pa_out));
    chk("pb_oe", 32'(b[27:16]), 32'(pb_oe));
    chk("pb_out", 32'(b[27:16] & b[11:0]), 32'(pb_oe & pb_out));
    chk("pa_per_in", 32'(pi), 32'(pa_per_in));
    chk("pb_per_in", 32'(sb_f & b[7:0]), 32'(pb_per_in));
    chk("refresh_req", 32'(s_sc & ~sb_d[8] & ext_b[8]), 32'(refresh_req));
    chk("pb_irq", 32'h0, 32'(pb_irq));
    for (int j = 0; j < 9; j++) rd(OFFS[j], e[j], 1'b0);
  endtask
  task automatic load(input int i);
    logic [31:0] v [9];
    for (int j = 0; j < 9; j++) v[j] = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : $random(seed);
    ext_a  <= 16'($random(seed));
    ext_b  <= 12'($random(seed));
    pao    <= 16'($random(seed));
    pae    <= 16'($random(seed));
    pbo    <= 7'($random(seed));
    pbe    <= 7'($random(seed));
    watchdog_output_n <= 1'($random(seed));
    sa_f = v[0][15:0];
    sa_d = v[1][15:0];
    sa_l = v[2][15:0];
    sb_f = v[3][7:0];
    sb_d = v[4][11:0];
    sb_l = v[5][11:0];
    s_sc = v[8][0];
    for (int j = 0; j < 9; j++) if (j < 6 || j == 8) wr(OFFS[j], v[j], 1'b0);
  endtask
  task automatic do_reset;
    resetn <= 1'b0;
    req    <= '0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    {sa_f, sa_d, sa_l, sb_d, sb_l, s_im, s_gi, s_sc} = '0;
    sb_f = 8'h80;
  endtask
  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    {ext_a, ext_b, pao, pae, pbo, pbe} = '0;
    watchdog_output_n = 1'b1;
    do_reset();
    look();
    wr(8'h24, $random(seed), 1'b1);
    rd(8'h24, 32'h0, 1'b1);
    for (int i = 0; i < 40; i++) begin
      load(i);
      look();
    end
    wr(pio_pkg::OFF_GLOBAL_INTERRUPT_MODE_REGISTER, 32'h1, 1'b0);
    for (int c = 0; c < 12; c++) begin
      n = c % 4;
      m = c / 4;
      ext_b <= 12'hF00;
      repeat (4) @(posedge clk);
      wr(pio_pkg::OFF_IMASK, (m == 1) ? 32'h0 : 32'h1 << n, 1'b0);
      wr(pio_pkg::OFF_PB_DIR, (m == 2) ? 32'h100 << n : 32'h0, 1'b0);
      repeat (4) @(posedge clk);
      ext_b <= 12'hF00 & ~(12'h100 << n);
      cnt = 4'h0;
      o = 4'h0;
      repeat (10) begin
        @(posedge clk);
        cnt = cnt + 4'(pb_irq[n]);
        o = o | (pb_irq & ~(4'h1 << n));
      end
      chk("pb_irq count", 32'(m == 0), 32'(cnt));
      chk("pb_irq other", 32'h0, 32'(o));
    end
    do_reset();
    look();
    test_done();
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
endmodule // pio_ports_bench
